// >>> verilog/bldc_drive_defines.svh
`ifndef BLDC_DRIVE_DEFINES_SVH
`define BLDC_DRIVE_DEFINES_SVH
// Notes on behaviour
// - Direction low commutes U,V,W; direction high commutes W,V,U.
// - Rotation pulse output is made only from hall signal transitions.
// - Pulse count select 1 gives three pulses per revolution, 0 gives one.
// - Speed command starts, stops the motor and sets output PWM duty.
// - Speed mode 2 is analog, 1 is pulse duty, 0 is test mode.
// - Analog start above low threshold; sequence resets at or below it.
// - Analog duty 0 at or below low, 1/128..127/128 between, 128/128 at high.
// - Pulse duty mode starts when a PWM signal appears on the input.
// - Pulse mode ignores highs of 0.2 us or less; 1 ms low means stop.
// - Minimum settings 1..7 give 10.9% to 20.3% minimum and start duty.
// - Minimum setting 8: no minimum, start at lesser of command and 20.3%.
// - Minimum setting 0: no minimum, start at lesser of command and 10.9%.
// - Carrier select 3,2,1,0 gives 25, 200, 100, 50 kHz.
// - Carrier choice is the same in analog and pulse duty modes.
// - Lead mode 2 phase match, 1 frequency profile, 0 external lead input.
// - A current zero crossing makes a zero-cross event.
// - Phase match compares hall and current zero crossings, adjusts lead.
// - Phase match offset: 32 lead steps map to +-28.125 degrees.
// - Offset sign inverts when direction select changes.
// - External lead is step times 1.875 degrees, at most 58.125 degrees.
// - Frequency lead uses 100 Hz bands with 50 Hz falling hysteresis.

// Register byte offsets
`define REG_CONFIG 4'h0
`define REG_SPEED_CODE 4'h4
`define REG_STATUS 4'h8
`define REG_LEAD 4'hc
// Config field positions
`define CFG_DIR_BIT 0
`define CFG_PULSE3_BIT 1
`define CFG_SPMODE_LSB 2
`define CFG_MINDUTY_LSB 4
`define CFG_CARRIER_LSB 8
`define CFG_LEADMODE_LSB 10
`define CFG_LEADIN_LSB 12
`define CFG_WIDTH 17
`define CFG_RESET 17'h00008
`define SPEED_CODE_RESET 8'h00
// Analog code: one step is one 256th of the regulator, 0.625 V is 32
`define SPEED_LOW_CODE 8'h20
`define SPEED_HIGH_CODE 8'ha0
`define DUTY_FULL 8'h80
`define START_DUTY_SMALL 8'h0e
`define START_DUTY_LARGE 8'h1a
// Timing
`define CLK_MHZ 100
`define CLK_HZ 100000000
`define CARRIER_25K_HZ 25000
`define CARRIER_50K_HZ 50000
`define CARRIER_100K_HZ 100000
`define CARRIER_200K_HZ 200000
`define SPEED_GLITCH_NS 200
`define SPEED_GLITCH_CYC ((`SPEED_GLITCH_NS * `CLK_MHZ) / 1000)
`define SPEED_STOP_US 1000
`define SPEED_STOP_CYC (`SPEED_STOP_US * `CLK_MHZ)
`define LEAD_BAND_HZ 100
`define LEAD_BANDS 20
`endif

// >>> verilog/bldc_drive_pkg.sv
package bldc_drive_pkg;
	typedef struct packed {
		logic [4:0] lead_input;
		logic [1:0] lead_mode_select;
		logic [1:0] carrier_frequency_select;
		logic [3:0] minimum_duty_select;
		logic [1:0] speed_input_mode_select;
		logic pulse_count_select;
		logic direction_select;
	} config_t;

	typedef struct packed {
		logic [2:0] high_side;
		logic [2:0] low_side;
	} phase_drive_t;

	typedef enum logic [1:0] {
		SPEED_TEST,
		SPEED_PULSE,
		SPEED_ANALOG,
		SPEED_RESERVED
	} speed_mode_t;

	typedef enum logic [1:0] {
		LEAD_EXTERNAL,
		LEAD_FREQUENCY,
		LEAD_PHASE_MATCH,
		LEAD_RESERVED
	} lead_mode_t;

	typedef enum {
		DRIVE_IDLE,
		DRIVE_START,
		DRIVE_RUN
	} drive_state_t;
endpackage

// >>> verilog/bldc_sine_drive_setup_control.sv
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "bldc_drive_defines.svh"
module bldc_sine_drive_setup_control #(
	parameter int STOP_CYCLES = `SPEED_STOP_CYC,
	parameter int CNT_W = 20,
	parameter int PERIOD_W = 24
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [2:0] hall_i,
	input wire logic speed_command_input_i,
	input wire logic current_zero_cross_i,
	output bldc_drive_pkg::phase_drive_t phase_drive_o,
	output logic rotation_pulse_output_o,
	output logic [4:0] lead_angle_o
);
	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	bldc_drive_pkg::config_t cfg;
	logic [7:0] speed_code;
	logic wr_pending;
	logic [3:0] wr_addr;
	logic [7:0] duty;
	bldc_drive_pkg::drive_state_t state;
	logic [2:0] hall;
	logic pulse_stopped;
	logic [4:0] lead_acc;
	logic [4:0] band;
	logic [31:0] next_rdata;
	logic addr_phase;

	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign addr_phase = hsel_i && htrans_i[1] && hready_i;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_pending <= 1'b0;
			wr_addr <= 4'h0;
		end else if (hready_i) begin
			wr_pending <= addr_phase && hwrite_i;
			wr_addr <= haddr_i[3:0];
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg <= bldc_drive_pkg::config_t'(`CFG_RESET);
			speed_code <= `SPEED_CODE_RESET;
		end else if (wr_pending) begin
			if (wr_addr == `REG_CONFIG)
				cfg <= bldc_drive_pkg::config_t'(hwdata_i[`CFG_WIDTH-1:0]);
			if (wr_addr == `REG_SPEED_CODE)
				speed_code <= hwdata_i[7:0];
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (haddr_i[3:0])
			`REG_CONFIG: next_rdata = {15'h0000, cfg};
			`REG_SPEED_CODE: next_rdata = {24'h00_0000, speed_code};
			`REG_STATUS: next_rdata = {17'h00000, pulse_stopped, state != bldc_drive_pkg::DRIVE_IDLE,
				hall, 2'(state), duty};
			`REG_LEAD: next_rdata = {17'h00000, band, lead_acc, lead_angle_o};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data is captured in the address phase so the slave needs no wait state
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			hrdata_o <= 32'h0000_0000;
		else if (addr_phase && !hwrite_i)
			hrdata_o <= next_rdata;
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [4:0] sync_a;
	logic [4:0] sync_b;
	logic [2:0] hall_prev;
	logic sp;
	logic sp_prev;
	logic izc;
	logic izc_prev;
	// Hall and current crossing edges are held off until both stages and the previous copy carry real pin levels
	logic [2:0] warm;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync_a <= 5'h00;
			sync_b <= 5'h00;
			hall_prev <= 3'h0;
			sp_prev <= 1'b0;
			izc_prev <= 1'b0;
			warm <= 3'h0;
		end else begin
			warm <= {warm[1:0], 1'b1};
			sync_a <= {current_zero_cross_i, speed_command_input_i, hall_i};
			sync_b <= sync_a;
			hall_prev <= hall;
			sp_prev <= sp;
			izc_prev <= izc;
		end
	end

	assign hall = sync_b[2:0];
	assign sp = sync_b[3];
	assign izc = sync_b[4];

	logic hall_edge;
	logic hall_u_rise;
	logic izc_event;
	assign hall_edge = warm[2] && hall != hall_prev;
	assign hall_u_rise = warm[2] && hall[2] && !hall_prev[2];
	assign izc_event = warm[2] && izc != izc_prev;

	// ----------------------------------------------------------------
	// Rotation pulse
	// ----------------------------------------------------------------
	// hall edges only
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			rotation_pulse_output_o <= 1'b0;
		else if (cfg.pulse_count_select) begin
			if (hall_edge)
				rotation_pulse_output_o <= !rotation_pulse_output_o;
		end else
			rotation_pulse_output_o <= hall[2];
	end

	// ----------------------------------------------------------------
	// Pulse duty measurement
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] run_len;
	logic [CNT_W-1:0] hi_acc;
	logic [CNT_W-1:0] per_cnt;
	logic [CNT_W-1:0] hi_meas;
	logic [CNT_W-1:0] per_meas;
	logic [7:0] pulse_duty;
	logic [7:0] quot;
	logic [3:0] div_step;
	logic [7:0] trial;
	logic run_long;
	assign run_long = run_len >= CNT_W'(STOP_CYCLES);
	assign trial = quot | (8'h80 >> div_step[2:0]);

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			run_len <= '0;
			hi_acc <= '0;
			per_cnt <= '0;
			hi_meas <= '0;
			per_meas <= '0;
			pulse_stopped <= 1'b1;
		end else begin
			run_len <= (sp != sp_prev) ? CNT_W'(1) : (run_long ? run_len : run_len + 1'b1);
			per_cnt <= per_cnt + {{(CNT_W-1){1'b0}}, !run_long};
			if (!sp && sp_prev && run_len > CNT_W'(`SPEED_GLITCH_CYC))
				hi_acc <= hi_acc + run_len;
			if (sp && !sp_prev) begin
				hi_meas <= hi_acc;
				per_meas <= per_cnt;
				hi_acc <= '0;
				per_cnt <= CNT_W'(1);
				pulse_stopped <= 1'b0;
			end else if (run_long)
				pulse_stopped <= 1'b1;
		end
	end

	// Successive approximation of high time * 128 / period, eight steps
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			quot <= 8'h00;
			div_step <= 4'h8;
			pulse_duty <= 8'h00;
		end else begin
			if (sp && !sp_prev) begin
				quot <= 8'h00;
				div_step <= 4'h0;
			end else if (!div_step[3]) begin
				if ((CNT_W+8)'(trial) * per_meas <= {hi_meas, 8'h00} >> 1)
					quot <= trial;
				div_step <= div_step + 4'h1;
			end
			if (run_long)
				pulse_duty <= sp ? `DUTY_FULL : 8'h00;
			else if (div_step == 4'h8 && per_meas != '0)
				pulse_duty <= (quot > `DUTY_FULL) ? `DUTY_FULL : quot;
		end
	end

	// ----------------------------------------------------------------
	// Speed command and startup
	// ----------------------------------------------------------------
	logic [7:0] cmd_duty;
	logic [7:0] min_duty;
	logic [7:0] start_duty;
	logic [7:0] run_duty;
	bldc_drive_pkg::drive_state_t next_state;

	always_comb begin
		cmd_duty = 8'h00;
		unique case (bldc_drive_pkg::speed_mode_t'(cfg.speed_input_mode_select))
			bldc_drive_pkg::SPEED_ANALOG: begin
				if (speed_code <= `SPEED_LOW_CODE)
					cmd_duty = 8'h00;
				else if (speed_code >= `SPEED_HIGH_CODE)
					cmd_duty = `DUTY_FULL;
				else
					cmd_duty = speed_code - `SPEED_LOW_CODE;
			end
			bldc_drive_pkg::SPEED_PULSE: cmd_duty = pulse_stopped ? 8'h00 : pulse_duty;
			bldc_drive_pkg::SPEED_TEST: cmd_duty = 8'h00;
			default: cmd_duty = 8'h00;
		endcase
	end

	always_comb begin
		min_duty = 8'h00;
		start_duty = 8'h00;
		if (cfg.minimum_duty_select == 4'h0)
			start_duty = (cmd_duty > `START_DUTY_SMALL) ? `START_DUTY_SMALL : cmd_duty;
		else if (cfg.minimum_duty_select >= 4'h8)
			start_duty = (cmd_duty > `START_DUTY_LARGE) ? `START_DUTY_LARGE : cmd_duty;
		else begin
			min_duty = 8'd12 + {3'h0, cfg.minimum_duty_select, 1'b0};
			start_duty = min_duty;
		end
	end
	assign run_duty = (cmd_duty < min_duty) ? min_duty : cmd_duty;

	always_comb begin
		next_state = state;
		unique case (state)
			bldc_drive_pkg::DRIVE_IDLE:
				if (cmd_duty != 8'h00)
					next_state = bldc_drive_pkg::DRIVE_START;
			bldc_drive_pkg::DRIVE_START:
				if (cmd_duty == 8'h00)
					next_state = bldc_drive_pkg::DRIVE_IDLE;
				else if (hall_edge)
					next_state = bldc_drive_pkg::DRIVE_RUN;
			bldc_drive_pkg::DRIVE_RUN:
				if (cmd_duty == 8'h00)
					next_state = bldc_drive_pkg::DRIVE_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= bldc_drive_pkg::DRIVE_IDLE;
			duty <= 8'h00;
		end else begin
			state <= next_state;
			unique case (next_state)
				bldc_drive_pkg::DRIVE_IDLE: duty <= 8'h00;
				bldc_drive_pkg::DRIVE_START: duty <= start_duty;
				bldc_drive_pkg::DRIVE_RUN: duty <= run_duty;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Carrier and commutation
	// ----------------------------------------------------------------
	logic [11:0] period;
	logic [11:0] carrier_cnt;
	logic pwm_on;

	always_comb begin
		unique case (cfg.carrier_frequency_select)
			2'd3: period = 12'(`CLK_HZ / `CARRIER_25K_HZ);
			2'd2: period = 12'(`CLK_HZ / `CARRIER_200K_HZ);
			2'd1: period = 12'(`CLK_HZ / `CARRIER_100K_HZ);
			2'd0: period = 12'(`CLK_HZ / `CARRIER_50K_HZ);
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			carrier_cnt <= 12'h000;
		else if (carrier_cnt >= period - 12'h001)
			carrier_cnt <= 12'h000;
		else
			carrier_cnt <= carrier_cnt + 12'h001;
	end
	assign pwm_on = {carrier_cnt, 7'h00} < 19'(duty) * 19'(period);

	// Block commutation from the hall code; reverse swaps the sides
	function automatic bldc_drive_pkg::phase_drive_t commutate(input logic [2:0] h,
		input logic rev);
		logic [5:0] fwd;
		fwd = 6'h00;
		unique case (h)
			3'b100: fwd = 6'b100_010;
			3'b110: fwd = 6'b100_001;
			3'b010: fwd = 6'b010_001;
			3'b011: fwd = 6'b010_100;
			3'b001: fwd = 6'b001_100;
			3'b101: fwd = 6'b001_010;
			default: fwd = 6'h00;
		endcase
		return rev ? {fwd[2:0], fwd[5:3]} : fwd;
	endfunction

	bldc_drive_pkg::phase_drive_t drive_sel;
	assign drive_sel = commutate(hall, cfg.direction_select);

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			phase_drive_o <= '0;
		else if (state == bldc_drive_pkg::DRIVE_IDLE)
			phase_drive_o <= '0;
		else
			phase_drive_o <= {drive_sel.high_side & {3{pwm_on}}, drive_sel.low_side};
	end

	// ----------------------------------------------------------------
	// Lead angle
	// ----------------------------------------------------------------
	// Frequency profile, one row per setting, in 1.875 degree steps
	localparam logic [4:0] LEAD_TABLE [0:167] = '{
		0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 19, 20,
		0, 2, 4, 6, 8, 10, 12, 14, 16, 18, 20, 22, 24, 26, 28, 30, 30, 30, 30, 30, 30,
		0, 2, 3, 5, 7, 9, 10, 12, 14, 16, 17, 19, 21, 23, 24, 26, 28, 30, 31, 31, 31,
		0, 1, 3, 4, 6, 7, 9, 10, 12, 13, 15, 16, 18, 19, 21, 22, 24, 25, 27, 28, 30,
		0, 1, 2, 3, 5, 6, 7, 8, 10, 11, 12, 13, 15, 16, 17, 18, 20, 21, 22, 23, 25,
		0, 1, 1, 2, 3, 4, 4, 5, 6, 7, 7, 8, 9, 10, 10, 11, 12, 13, 13, 14, 15,
		0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 5, 6, 6, 7, 7, 8, 8, 9, 9, 10, 10,
		0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 4, 4, 4, 4, 5, 5, 5, 5
	};

	logic [PERIOD_W-1:0] elec_cnt;
	logic [PERIOD_W-1:0] elec_period;
	logic [4:0] up_band;
	logic [4:0] keep_band;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			elec_cnt <= '0;
			elec_period <= '1;
		end else if (hall_u_rise) begin
			elec_period <= elec_cnt;
			elec_cnt <= '0;
		end else if (elec_cnt != '1)
			elec_cnt <= elec_cnt + 1'b1;
	end

	always_comb begin
		up_band = 5'h00;
		keep_band = 5'h00;
		for (int b = 1; b <= `LEAD_BANDS; b++) begin
			if (40'(elec_period) * 40'(b * `LEAD_BAND_HZ) <= 40'(`CLK_HZ))
				up_band = 5'(b);
			if (40'(elec_period) * 40'(b * 2 - 1) * 40'(`LEAD_BAND_HZ / 2) <= 40'(`CLK_HZ))
				keep_band = 5'(b);
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			band <= 5'h00;
		else if (up_band > band)
			band <= up_band;
		else if (keep_band < band)
			band <= keep_band;
	end

	// steer lead to align zero crossings
	logic hall_pending;
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hall_pending <= 1'b0;
			lead_acc <= 5'h00;
		end else begin
			if (hall_u_rise)
				hall_pending <= 1'b1;
			else if (izc_event)
				hall_pending <= 1'b0;
			// Current after hall edge means lagging current: advance more
			if (izc_event && !hall_u_rise) begin
				if (hall_pending && lead_acc != 5'h1f)
					lead_acc <= lead_acc + 5'h01;
				else if (!hall_pending && lead_acc != 5'h00)
					lead_acc <= lead_acc - 5'h01;
			end
		end
	end

	logic signed [6:0] offset;
	logic signed [6:0] matched;
	logic [7:0] tbl_idx;
	always_comb begin
		offset = cfg.lead_input[4] ? -7'(cfg.lead_input[3:0]) : 7'(cfg.lead_input[3:0]);
		if (cfg.direction_select)
			offset = -offset;
		matched = 7'(lead_acc) + offset;
	end
	assign tbl_idx = 8'(7 - cfg.lead_input[4:2]) * 8'd21 + 8'(band);

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			lead_angle_o <= 5'h00;
		else
			unique case (bldc_drive_pkg::lead_mode_t'(cfg.lead_mode_select))
				bldc_drive_pkg::LEAD_PHASE_MATCH:
					lead_angle_o <= matched < 0 ? 5'h00 : (matched > 31 ? 5'h1f : 5'(matched));
				bldc_drive_pkg::LEAD_FREQUENCY: lead_angle_o <= LEAD_TABLE[tbl_idx];
				bldc_drive_pkg::LEAD_EXTERNAL: lead_angle_o <= cfg.lead_input;
				default: lead_angle_o <= 5'h00;
			endcase
	end
endmodule // bldc_sine_drive_setup_control

// >>> dv/drive_checker_assertions.sv
`timescale 1ns/1ps
module drive_checker #(
	parameter int STOP_CYCLES = 2000
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic [2:0] hall_i,
	input wire bldc_drive_pkg::phase_drive_t phase_drive_o,
	input wire logic rotation_pulse_output_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	logic rd;
	logic wr;
	logic [2:0] hall_q;
	logic [3:0] quiet;
	assign rd = hsel_i & htrans_i[1] & hready_i & !hwrite_i;
	assign wr = hsel_i & htrans_i[1] & hready_i & hwrite_i;

	// Config writes may re-select the pulse source, so they restart the count too
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hall_q <= 3'h0;
			quiet <= 4'h0;
		end else begin
			hall_q <= hall_i;
			if (hall_i != hall_q || wr)
				quiet <= 4'h0;
			else if (quiet != 4'hf)
				quiet <= quiet + 4'h1;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	bus_okay_a: assert property (hreadyout_o && !hresp_o)
		else $error("bus answer not ready or not okay");
	phase_excl_a: assert property ((phase_drive_o.high_side & phase_drive_o.low_side) == 3'h0)
		else $error("high and low side on in one phase");
	low_onehot_a: assert property ($onehot0(phase_drive_o.low_side))
		else $error("more than one low side on");
	high_low_a: assert property (phase_drive_o.high_side != 3'h0 |-> phase_drive_o.low_side != 3'h0)
		else $error("high side on with no return path");
	pulse_src_a: assert property ($changed(rotation_pulse_output_o) |-> quiet <= 4'h6)
		else $error("rotation pulse moved without a hall edge");
	status_duty_a: assert property (rd && haddr_i[3:0] == 4'h8 |=>
		hrdata_o[7:0] <= 8'h80 && hrdata_o[9:8] != 2'h3)
		else $error("duty above full scale or bad state");
	cfg_width_a: assert property (rd && haddr_i[3:0] == 4'h0 |=> hrdata_o[31:17] == 15'h0)
		else $error("config reads beyond its fields");
	rdata_hold_a: assert property (!rd |=> $stable(hrdata_o))
		else $error("read data moved without a read");

	cover property (rd ##1 hrdata_o[9:8] == 2'h2);
	cover property ($rose(rotation_pulse_output_o));
	cover property (phase_drive_o.high_side != 3'h0);
endmodule // drive_checker

bind bldc_sine_drive_setup_control drive_checker #(.STOP_CYCLES(STOP_CYCLES)) i_chk (
	.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
	.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hall_i(hall_i),
	.phase_drive_o(phase_drive_o), .rotation_pulse_output_o(rotation_pulse_output_o)
);

// >>> dv/motor_host_model.sv
`timescale 1ns/1ps
module motor_host_model (
	input wire logic clk_i,
	input wire logic step_i,
	input wire logic pwm_en_i,
	input wire logic [15:0] period_i,
	input wire logic [15:0] high_i,
	output logic [2:0] hall_o,
	output logic speed_o,
	output logic izc_o
);
	logic [2:0] seq [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
	logic [2:0] pos = 3'h0;
	logic [1:0] lag = 2'h0;
	logic [15:0] cnt = 16'h0;
	assign hall_o = seq[pos];
	initial izc_o = 1'b0;
	initial speed_o = 1'b0;

	// Hall advance and a current crossing two cycles after each U rise
	always_ff @(posedge clk_i) begin
		if (step_i)
			pos <= (pos == 3'h5) ? 3'h0 : pos + 3'h1;
		lag <= {lag[0], step_i && pos == 3'h4};
		if (lag[1])
			izc_o <= !izc_o;
	end

	// command rate
	// Line held low when off, which the drive must read as a stop
	always_ff @(posedge clk_i) begin
		cnt <= (!pwm_en_i || cnt >= period_i - 16'h1) ? 16'h0 : cnt + 16'h1;
		speed_o <= pwm_en_i && cnt < high_i;
	end
endmodule // motor_host_model

// >>> dv/tb_bldc_sine_drive_setup_control.sv
`timescale 1ns/1ps
module tb_bldc_sine_drive_setup_control;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready;
	logic [2:0] hall;
	logic spd, izc, rpo, rpo_q, hi_q, rise;
	logic step = 1'b0;
	logic pwm_en = 1'b0;
	logic [15:0] period = 16'h03e8;
	logic [15:0] high = 16'h01f4;
	logic [4:0] lead;
	bldc_drive_pkg::phase_drive_t drv;
	int fails = 0;
	int comparisons = 0;
	int rises = 0;
	int cycles = 0;

	always #5 clk = ~clk;
	assign rise = |drv.high_side && !hi_q;

	bldc_sine_drive_setup_control #(.STOP_CYCLES(2000)) i_dut (.sys_clk_i(clk),
		.resetn_i(resetn), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(), .hall_i(hall),
		.speed_command_input_i(spd), .current_zero_cross_i(izc), .phase_drive_o(drv),
		.rotation_pulse_output_o(rpo), .lead_angle_o(lead));

	motor_host_model i_host (.clk_i(clk), .step_i(step), .pwm_en_i(pwm_en),
		.period_i(period), .high_i(high), .hall_o(hall), .speed_o(spd), .izc_o(izc));

	always @(posedge clk) begin
		rpo_q <= rpo;
		hi_q <= |drv.high_side;
		if (rpo && !rpo_q)
			rises++;
		cycles++;
		if (cycles == 60000) begin
			fails++;
			results();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task results;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task rst;
		resetn <= 1'b0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
	endtask

	task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {28'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task status(input logic [7:0] d, input logic [1:0] s);
		logic [31:0] x;
		repeat (12) @(posedge clk);
		bus(1'b0, 4'h8, 32'h0, x);
		check(x[7:0], d);
		check(x[9:8], s);
	endtask

	task turn(input int n);
		repeat (n) begin
			step <= 1'b1;
			@(posedge clk);
			step <= 1'b0;
			repeat (10) @(posedge clk);
		end
	endtask

	function automatic logic [31:0] cfg(input logic [4:0] li, input logic [1:0] lm, c,
		input logic [3:0] md, input logic [1:0] sm, input logic pc, r);
		return {15'h0, li, lm, c, md, sm, pc, r};
	endfunction

	function automatic logic [5:0] exp_drv(input logic [2:0] h, input logic r);
		logic [5:0] e;
		case (h)
			3'h4: e = 6'h22;
			3'h6: e = 6'h21;
			3'h2: e = 6'h11;
			3'h3: e = 6'h14;
			3'h1: e = 6'h0c;
			default: e = 6'h0a;
		endcase
		return r ? {e[2:0], e[5:3]} : e;
	endfunction

	task carrier(input logic [1:0] sm, input logic [1:0] c, input int p);
		int n;
		wr(4'h0, cfg(5'h0, 2'h0, c, 4'h0, sm, 1'b0, 1'b0));
		n = 0;
		repeat (2) do @(posedge clk); while (!rise);
		do begin
			@(posedge clk);
			n++;
		end while (!rise);
		check(n, p);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		logic [31:0] x;
		bus(1'b0, 4'h0, 32'h0, x);
		check(x, 32'h0000_0008);
		bus(1'b0, 4'h4, 32'h0, x);
		check(x, 32'h0);
		wr(4'h0, 32'hffff_ffff);
		bus(1'b0, 4'h0, 32'h0, x);
		check(x, 32'h0001_ffff);
		wr(4'h0, 32'h0000_0008);
		wr(4'h8, 32'hffff_ffff);
		status(8'h00, 2'h0);
		$display("registers done");
	endtask

	task automatic t_analog;
		logic [7:0] c[4] = '{8'h60, 8'h9f, 8'ha0, 8'hff};
		logic [7:0] e[4] = '{8'h40, 8'h7f, 8'h80, 8'h80};
		wr(4'h0, cfg(5'h0, 2'h0, 2'h0, 4'h0, 2'h2, 1'b0, 1'b0));
		wr(4'h4, 32'h21);
		status(8'h01, 2'h1);
		turn(1);
		for (int k = 0; k < 4; k++) begin
			wr(4'h4, {24'h0, c[k]});
			status(e[k], 2'h2);
		end
		wr(4'h4, 32'h20);
		status(8'h00, 2'h0);
		wr(4'h0, cfg(5'h0, 2'h0, 2'h0, 4'h0, 2'h0, 1'b0, 1'b0));
		wr(4'h4, 32'hc8);
		status(8'h00, 2'h0);
		wr(4'h4, 32'h0);
		$display("analog done");
	endtask

	task t_start;
		for (int s = 0; s <= 8; s++) begin
			wr(4'h4, 32'h0);
			wr(4'h0, cfg(5'h0, 2'h0, 2'h0, s[3:0], 2'h2, 1'b0, 1'b0));
			wr(4'h4, 32'h60);
			status(s == 0 ? 8'h0e : s == 8 ? 8'h1a : 8'(12 + 2 * s), 2'h1);
		end
		for (int s = 0; s <= 8; s += 8) begin
			wr(4'h4, 32'h0);
			wr(4'h0, cfg(5'h0, 2'h0, 2'h0, s[3:0], 2'h2, 1'b0, 1'b0));
			wr(4'h4, 32'h28);
			status(8'h08, 2'h1);
		end
		wr(4'h4, 32'h0);
		wr(4'h0, cfg(5'h0, 2'h0, 2'h0, 4'h7, 2'h2, 1'b0, 1'b0));
		wr(4'h4, 32'h28);
		turn(1);
		status(8'h1a, 2'h2);
		wr(4'h4, 32'h0);
		$display("start duty done");
	endtask

	task t_commute;
		for (int d = 0; d < 2; d++) begin
			wr(4'h0, cfg(5'h0, 2'h0, 2'h0, 4'h0, 2'h2, d[0], d[0]));
			wr(4'h4, 32'hc8);
			turn(1);
			rises = 0;
			repeat (6) begin
				turn(1);
				check(drv, exp_drv(hall, d[0]));
				if (d == 0)
					check(rpo, hall[2]);
			end
			check(rises, d == 0 ? 1 : 3);
		end
		wr(4'h4, 32'h0);
		$display("commutation done");
	endtask

	task automatic t_lead;
		logic [4:0] li[7] = '{5'h00, 5'h1f, 5'h05, 5'h05, 5'h14, 5'h14, 5'h07};
		logic [1:0] lm[7] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1};
		logic dr[7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
		logic [4:0] ex[7] = '{5'h00, 5'h1f, 5'h05, 5'h00, 5'h00, 5'h04, 5'h00};
		rst();
		for (int k = 0; k < 7; k++) begin
			wr(4'h0, cfg(li[k], lm[k], 2'h0, 4'h0, 2'h2, 1'b0, dr[k]));
			repeat (12) @(posedge clk);
			check(lead, ex[k]);
		end
		$display("lead done");
	endtask

	task t_pulse;
		wr(4'h0, cfg(5'h0, 2'h0, 2'h0, 4'h0, 2'h1, 1'b0, 1'b0));
		pwm_en <= 1'b1;
		repeat (4000) @(posedge clk);
		status(8'h0e, 2'h1);
		turn(1);
		status(8'h40, 2'h2);
		high <= 16'h00fa;
		repeat (3000) @(posedge clk);
		status(8'h20, 2'h2);
		carrier(2'h1, 2'h0, 2000);
		carrier(2'h1, 2'h1, 1000);
		carrier(2'h1, 2'h2, 500);
		carrier(2'h1, 2'h3, 4000);
		pwm_en <= 1'b0;
		repeat (2200) @(posedge clk);
		status(8'h00, 2'h0);
		wr(4'h4, 32'h60);
		carrier(2'h2, 2'h2, 500);
		$display("pulse duty done");
	endtask

	initial begin
		rst();
		t_regs();
		t_analog();
		t_start();
		t_commute();
		t_lead();
		t_pulse();
		results();
	end
endmodule // tb_bldc_sine_drive_setup_control
